// File: logic/srs_pkg.sv
// package for the standby and reset sequencer: offsets, fields, timings
package srs_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] SRS_OFF_CTRL = 8'h00; // settle select + lowv control
  localparam logic [7:0] SRS_OFF_STATUS = 8'h04; // settle status counter
  localparam logic [7:0] SRS_OFF_CAUSE = 8'h08; // reset cause register
  localparam logic [7:0] SRS_OFF_STATE = 8'h0C; // power state readback
  // control register fields
  localparam int SRS_CTRL_SEL_LSB = 0; // settle_time_select, 3 bits
  localparam int SRS_CTRL_LVEN_BIT = 8; // lowv_enable
  localparam int SRS_CTRL_LVMD_BIT = 9; // lowv_reset_mode_sel
  localparam int SRS_CTRL_LVSRC_BIT = 10; // lowv_source_sel
  // reset cause fields
  localparam int SRS_CAUSE_LV_BIT = 0; // lowv_reset_cause
  localparam int SRS_CAUSE_WD_BIT = 4; // wdog_reset_cause
  localparam int SRS_CAUSE_TRAP_BIT = 7; // illegal instruction cause
  // reset values
  localparam logic [2:0] SRS_SEL_RST = 3'h7; // longest settle after reset
  localparam logic [7:0] SRS_CAUSE_RST = 8'h00;
  localparam logic [31:0] SRS_SLVERR_DATA = 32'h0000_0000;
  // settle status counter width (bits fill from the msb)
  localparam int SRS_STAT_W = 8;
  // settle wait steps in aclk cycles: 2^(SRS_SETTLE_BASE + sel)
  localparam int SRS_SETTLE_BASE = 8;
  localparam int SRS_CNT_W = 19;
  // least settle time in ns; shorter programmings are illegal, though sel_q takes any value (select 0 waits 256 cycles)
  localparam int SRS_SETTLE_MIN_NS = 20000;
  localparam int SRS_CLK_NS = 10;
  localparam int SRS_SETTLE_MIN_CYC =
    (SRS_SETTLE_MIN_NS + SRS_CLK_NS - 1) / SRS_CLK_NS;
  // least external reset low time in ns
  localparam int SRS_EXT_RST_NS = 10000;
  localparam int SRS_EXT_RST_CYC =
    (SRS_EXT_RST_NS + SRS_CLK_NS - 1) / SRS_CLK_NS;
  // axi response codes
  localparam logic [1:0] SRS_RESP_OKAY = 2'b00;
  localparam logic [1:0] SRS_RESP_SLVERR = 2'b10;
  // power states, one-hot
  typedef enum logic [3:0] {
    SRS_RUN = 4'b0001,
    SRS_HALT = 4'b0010,
    SRS_STOP = 4'b0100,
    SRS_SETTLE = 4'b1000
  } srs_state_t;
endpackage

// File: logic/srs_settle_counter.sv
// crystal settle counter and its msb-first status bits
`timescale 1ns/1ns
module srs_settle_counter import srs_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic restart,
  input wire logic osc_running,
  input wire logic [2:0] sel,
  // results
  output logic [SRS_STAT_W-1:0] status,
  output logic done
);
  logic [SRS_CNT_W-1:0] cnt_q; // cycles counted since oscillation began
  logic [SRS_STAT_W-1:0] stat_q; // sticky status bits
  logic [SRS_STAT_W-1:0] hit; // per-step elapse flags
  logic cnt_top; // selected wait reached

  // step k elapses at 2^(base+k); only steps up to sel may report
  genvar k;
  generate
    for (k = 0; k < SRS_STAT_W; k++) begin : g_step
      assign hit[SRS_STAT_W-1-k] = (k <= int'(sel)) &&
        cnt_q[SRS_SETTLE_BASE+k];
    end
  endgenerate
  assign cnt_top = cnt_q[SRS_SETTLE_BASE + int'(sel)];

  // count only while oscillating; restart clears everything
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      cnt_q <= '0;
      stat_q <= '0;
    end else begin
      if (osc_running && !cnt_top) begin
        cnt_q <= cnt_q + 1'b1;
      end
      stat_q <= stat_q | hit;
    end
  end

  assign status = stat_q;
  assign done = cnt_top;
endmodule // srs_settle_counter

// File: logic/srs_sequencer.sv
// standby, settle wait and reset sequencer with axi4-lite registers
//
// Notes on behaviour
// - status counts only to the selected wait
// - wait starts once oscillation has begun
// - pending unmasked interrupt turns stop into halt
// - stop refused on fast internal clock
// - low-speed oscillator stops in stop only if option clear
// - reset stops all oscillators, ignores clock input
// - ram held through reset ending stop
// - reset: one port low, others released
// - lowv reset spares the lowv detector
// - watchdog reset also resets the watchdog
// - only three cause bits defined on read
// - lowv cause may read one after power-on
// - hold reset until supply above threshold
// - power-on-clear clears cause register to zero
// - lowv interrupt request clears lowv enable
// - status bits set msb first, stay set
`timescale 1ns/1ns
module srs_sequencer import srs_pkg::*; (
  // clock and reset (aresetn is the sequencer's own bus reset)
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // cpu side
  input wire logic stop_req,
  input wire logic halt_req,
  input wire logic irq_pending,
  input wire logic cpu_on_crystal,
  input wire logic cpu_on_fast_int,
  input wire logic trap_event,
  // reset sources (pins asynchronous; wdog_overflow is used unsynchronised)
  input wire logic ext_reset_n_pin,
  input wire logic pwrclr_reset_n_pin,
  input wire logic lowv_below_pin,
  input wire logic ext_voltage_pin,
  input wire logic wdog_overflow,
  // option bytes
  input wire logic wdog_in_standby_opt,
  input wire logic lowv_default_start_opt,
  // oscillator side
  input wire logic crystal_main_osc_running,
  output logic crystal_main_osc_en,
  output logic crystal_sub_osc_en,
  output logic int_fast_osc_en,
  output logic int_slow_osc_en,
  output logic ext_clk_in_en,
  // system outputs
  output logic sys_reset_n,
  output logic wdog_reset,
  output logic lowv_reset_n,
  output logic ram_hold,
  output logic reset_low_port_pin,
  output logic ports_hiz,
  output logic cpu_stalled,
  output logic lowv_irq
);
  // --- pin synchronisers: two flops, only stage two is read ---
  logic [4:0] sync1_q; // first stage
  logic [4:0] sync2_q; // second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 5'h03; // resting levels: ext, power-on-clear high
      sync2_q <= 5'h03; // supply starts above threshold, no false lowv
    end else begin
      sync1_q <= {ext_voltage_pin, lowv_below_pin, crystal_main_osc_running,
                  pwrclr_reset_n_pin, ext_reset_n_pin};
      sync2_q <= sync1_q;
    end
  end
  logic ext_rst_n_s, pwrclr_rst_n_s, osc_run_s, lowv_below_s, ext_volt_s;
  assign ext_rst_n_s = sync2_q[0];
  assign pwrclr_rst_n_s = sync2_q[1];
  assign osc_run_s = sync2_q[2];
  assign lowv_below_s = sync2_q[3];
  assign ext_volt_s = sync2_q[4];

  // --- registers ---
  logic [2:0] sel_q; // settle_time_select
  logic lowv_enable_q; // detector on
  logic lowv_reset_mode_sel_q; // 1: reset, 0: interrupt
  logic lowv_source_sel_q; // 1: external pin
  logic [7:0] cause_q; // reset_cause_reg
  logic lowv_irq_flag_q; // request pulse register
  srs_state_t state_q, state_d;
  logic [13:0] ext_lo_q; // external reset low-time counter
  logic restart; // settle counter restart
  logic settle_done;
  logic [SRS_STAT_W-1:0] status;

  // lowv detection on chosen source, only while enabled
  logic lowv_low;
  assign lowv_low = lowv_enable_q &&
    (lowv_source_sel_q ? ext_volt_s : lowv_below_s);
  logic lowv_rst, lowv_int;
  assign lowv_rst = lowv_low && lowv_reset_mode_sel_q;
  assign lowv_int = lowv_low && !lowv_reset_mode_sel_q;

  // external reset counts only after a full low interval
  logic ext_rst;
  assign ext_rst = (ext_lo_q >= 14'(SRS_EXT_RST_CYC));
  always_ff @(posedge aclk) begin
    if (!aresetn || ext_rst_n_s) begin
      ext_lo_q <= '0;
    end else if (!ext_rst) begin
      ext_lo_q <= ext_lo_q + 14'h0001;
    end
  end

  // power-on-clear and lowv default start hold reset until supply good
  logic pwrclr_rst, hold_rst, any_rst;
  assign pwrclr_rst = !pwrclr_rst_n_s;
  assign hold_rst = !lowv_default_start_opt && lowv_below_s;
  assign any_rst = pwrclr_rst || hold_rst || ext_rst || lowv_rst ||
    wdog_overflow;

  // --- axi4-lite write ---
  logic aw_q, w_q, bvalid_q;
  logic [3:0] wstrb_q; // held write strobes
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wr_go;
  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;
  assign wr_go = aw_q && w_q && !bvalid_q;
  logic wr_ok;
  assign wr_ok = (awaddr_q == SRS_OFF_CTRL) ||
    (awaddr_q == SRS_OFF_STATUS) || (awaddr_q == SRS_OFF_CAUSE) ||
    (awaddr_q == SRS_OFF_STATE);
  logic wr_ctrl_b0, wr_ctrl_b1;
  assign wr_ctrl_b0 = wr_go && (awaddr_q == SRS_OFF_CTRL) && wstrb_q[0];
  assign wr_ctrl_b1 = wr_go && (awaddr_q == SRS_OFF_CTRL) && wstrb_q[1];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bresp <= SRS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        s_axi_bresp <= wr_ok ? SRS_RESP_OKAY : SRS_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;

  // --- axi4-lite read ---
  logic rvalid_q;
  logic [31:0] rdata_d;
  logic rd_ok;
  assign s_axi_arready = !rvalid_q;
  // undefined cause bits are simply read as zero here
  assign rd_ok = (s_axi_araddr[7:2] <= SRS_OFF_STATE[7:2]);
  assign rdata_d =
    (s_axi_araddr[7:2] == SRS_OFF_CTRL[7:2]) ?
      {21'h00_0000, lowv_source_sel_q, lowv_reset_mode_sel_q,
       lowv_enable_q, 5'h00, sel_q} :
    (s_axi_araddr[7:2] == SRS_OFF_STATUS[7:2]) ?
      {24'h00_0000, status} :
    (s_axi_araddr[7:2] == SRS_OFF_CAUSE[7:2]) ?
      {24'h00_0000, cause_q & 8'h91} :
    (s_axi_araddr[7:2] == SRS_OFF_STATE[7:2]) ?
      {27'h000_0000, settle_done, state_q} :
      SRS_SLVERR_DATA;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= SRS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rd_ok ? SRS_RESP_OKAY : SRS_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;

  // --- control and cause registers ---
  // settle select changes are ignored while a crystal wait runs
  logic sel_lock;
  assign sel_lock = (state_q == SRS_SETTLE) && !settle_done;
  always_ff @(posedge aclk) begin
    if (!aresetn || pwrclr_rst) begin
      sel_q <= SRS_SEL_RST;
      lowv_enable_q <= !lowv_default_start_opt;
      lowv_reset_mode_sel_q <= !lowv_default_start_opt;
      lowv_source_sel_q <= 1'b0;
      cause_q <= SRS_CAUSE_RST;
      lowv_irq_flag_q <= 1'b0;
    end else begin
      if (wr_ctrl_b0 && !sel_lock) begin
        sel_q <= wdata_q[2:0];
      end
      // a lowv reset leaves the detector's own settings alone
      if (any_rst && !lowv_rst) begin
        lowv_enable_q <= !lowv_default_start_opt;
        lowv_reset_mode_sel_q <= !lowv_default_start_opt;
        lowv_source_sel_q <= 1'b0;
      end else if (lowv_int) begin
        lowv_enable_q <= 1'b0;
      end else if (wr_ctrl_b1) begin
        lowv_enable_q <= wdata_q[SRS_CTRL_LVEN_BIT];
        lowv_reset_mode_sel_q <= wdata_q[SRS_CTRL_LVMD_BIT];
        lowv_source_sel_q <= wdata_q[SRS_CTRL_LVSRC_BIT];
      end
      lowv_irq_flag_q <= lowv_int;
      // causes: power-on-clear wins over an event set; only power-on-clear or aresetn clears them, not a read or a cpu reset
      if (wdog_overflow) begin
        cause_q[SRS_CAUSE_WD_BIT] <= 1'b1;
      end
      if (lowv_rst || hold_rst) begin
        cause_q[SRS_CAUSE_LV_BIT] <= 1'b1;
      end
      if (trap_event) begin
        cause_q[SRS_CAUSE_TRAP_BIT] <= 1'b1;
      end
    end
  end
  assign lowv_irq = lowv_irq_flag_q;

  // --- standby state machine ---
  logic stop_ok;
  assign stop_ok = stop_req && !cpu_on_fast_int;
  always_comb begin
    state_d = state_q;
    case (state_q)
      SRS_RUN: begin
        if (stop_ok && irq_pending) begin
          state_d = SRS_HALT;
        end else if (stop_ok) begin
          state_d = SRS_STOP;
        end else if (halt_req) begin
          state_d = SRS_HALT;
        end
      end
      SRS_HALT: begin
        if (irq_pending) begin
          state_d = stop_ok ? SRS_SETTLE : SRS_RUN;
        end
      end
      SRS_STOP: begin
        if (irq_pending) begin
          state_d = SRS_SETTLE;
        end
      end
      SRS_SETTLE: begin
        if (settle_done) begin
          state_d = SRS_RUN;
        end
      end
      default: state_d = SRS_RUN;
    endcase
  end
  logic was_stop_q; // stop was entered before the current reset
  always_ff @(posedge aclk) begin
    if (!aresetn || any_rst) begin
      state_q <= SRS_RUN;
    end else begin
      state_q <= state_d;
    end
    if (!aresetn) begin
      was_stop_q <= 1'b0;
    end else if (state_q == SRS_STOP) begin
      was_stop_q <= 1'b1;
    end else if (!any_rst) begin
      was_stop_q <= 1'b0;
    end
  end
  logic rst_q; // registered reset, to find its release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_q <= 1'b1;
    end else begin
      rst_q <= any_rst;
    end
  end
  // restart at stop entry, at every settle entry (halt fallback too,
  // else a stale count would end the wait at once) and at reset release
  assign restart = (state_q != SRS_STOP && state_d == SRS_STOP) ||
    (state_q != SRS_SETTLE && state_d == SRS_SETTLE) ||
    (rst_q && !any_rst);

  srs_settle_counter u_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(restart),
    .osc_running(osc_run_s),
    .sel(sel_q),
    .status(status),
    .done(settle_done)
  );

  // --- outputs ---
  logic in_stop;
  assign in_stop = (state_q == SRS_STOP);
  assign sys_reset_n = !rst_q;
  assign wdog_reset = wdog_overflow || rst_q;
  assign lowv_reset_n = !(pwrclr_rst || ext_rst);
  assign ram_hold = in_stop || (rst_q && was_stop_q);
  assign crystal_main_osc_en = !rst_q && !in_stop;
  assign crystal_sub_osc_en = !rst_q;
  assign int_fast_osc_en = !rst_q && !in_stop;
  assign int_slow_osc_en = !rst_q &&
    !(in_stop && !wdog_in_standby_opt);
  assign ext_clk_in_en = !rst_q;
  assign reset_low_port_pin = rst_q;
  assign ports_hiz = rst_q;
  assign cpu_stalled = (state_q != SRS_RUN) || rst_q;

  // --- assertions ---
  property p_fast_no_stop;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == SRS_RUN && cpu_on_fast_int && !any_rst) |=>
      state_q != SRS_STOP;
  endproperty
  a_fast_no_stop: assert property (p_fast_no_stop)
    else $error("stop entered on fast internal clock");
  property p_pend_halt;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == SRS_RUN && stop_ok && irq_pending && !any_rst) |=>
      state_q == SRS_HALT;
  endproperty
  a_pend_halt: assert property (p_pend_halt)
    else $error("pending interrupt did not turn stop into halt");
  property p_osc_off_rst;
    @(posedge aclk) disable iff (!aresetn)
    rst_q |-> !crystal_main_osc_en && !int_slow_osc_en && !ext_clk_in_en;
  endproperty
  a_osc_off_rst: assert property (p_osc_off_rst)
    else $error("oscillator enabled during reset");
  property p_pwrclr_clear;
    @(posedge aclk) disable iff (!aresetn)
    pwrclr_rst |=> cause_q == 8'h00;
  endproperty
  a_pwrclr_clear: assert property (p_pwrclr_clear)
    else $error("cause register not cleared by power-on-clear");
  property p_lowv_irq_off;
    @(posedge aclk) disable iff (!aresetn)
    (lowv_int && !any_rst && !pwrclr_rst) |=> !lowv_enable_q && lowv_irq;
  endproperty
  a_lowv_irq_off: assert property (p_lowv_irq_off)
    else $error("lowv interrupt did not clear enable");
  property p_hold_rst;
    @(posedge aclk) disable iff (!aresetn)
    hold_rst |=> !sys_reset_n;
  endproperty
  a_hold_rst: assert property (p_hold_rst)
    else $error("reset released below threshold");
  property p_wdog;
    @(posedge aclk) disable iff (!aresetn)
    wdog_overflow |-> wdog_reset ##1 cause_q[SRS_CAUSE_WD_BIT] || pwrclr_rst;
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog reset missing");
  property p_stat_sticky;
    @(posedge aclk) disable iff (!aresetn)
    (!restart && status[SRS_STAT_W-1]) |=> status[SRS_STAT_W-1] || restart;
  endproperty
  a_stat_sticky: assert property (p_stat_sticky)
    else $error("status msb dropped without restart");
endmodule // srs_sequencer

// File: tb/srs_osc_model.sv
// crystal oscillator and reset pin stand-in facing the sequencer
`timescale 1ns/1ns
module srs_osc_model import srs_pkg::*; #(
  parameter int STARTUP = 40 // cycles before oscillation begins
) (
  // clock
  input wire logic aclk,
  // crystal side
  input wire logic osc_en,
  output logic osc_running,
  // reset pin side
  input wire logic pin_go,
  output logic ext_reset_n_pin
);
  int start_q = 0; // start-up cycles seen since enable
  int low_q = 0; // reset pin low cycles still to go
  // no oscillation during start-up; it stops as soon as it is disabled
  always_ff @(posedge aclk) begin
    if (!osc_en) begin
      start_q <= 0;
    end else if (start_q < STARTUP) begin
      start_q <= start_q + 1;
    end
    // pin held low a little beyond the least legal time
    if (pin_go) begin
      low_q <= SRS_EXT_RST_CYC + 5;
    end else if (low_q > 0) begin
      low_q <= low_q - 1;
    end
  end
  assign osc_running = osc_en && (start_q >= STARTUP);
  assign ext_reset_n_pin = (low_q == 0);
endmodule // srs_osc_model

// File: tb/srs_sequencer_bench.sv
// self-checking bench for the standby and reset sequencer
`timescale 1ns/1ns
module srs_sequencer_bench import srs_pkg::*;;
  localparam int STARTUP = 40; // crystal start-up in the model
  localparam int WAIT3 = 1 << (SRS_SETTLE_BASE + 3); // settle, select 3
  localparam int LIMIT = 90000; // hang guard in cycles
  // one register access and what it should give
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [31:0] m;
    logic [31:0] e;
    logic [1:0] resp;
  } srs_row_t;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic stop_req = 0, halt_req = 0, irq_pending = 0, trap_event = 0;
  logic cpu_on_crystal = 1, cpu_on_fast_int = 0, wdog_overflow = 0;
  logic pwrclr_reset_n_pin = 1, lowv_below_pin = 0, ext_voltage_pin = 0;
  logic wdog_in_standby_opt = 1, lowv_default_start_opt = 1;
  logic pin_go = 0, ext_reset_n_pin, crystal_main_osc_running;
  logic crystal_main_osc_en, crystal_sub_osc_en, int_fast_osc_en;
  logic int_slow_osc_en, ext_clk_in_en, sys_reset_n, wdog_reset;
  logic lowv_reset_n, ram_hold, reset_low_port_pin, ports_hiz;
  logic cpu_stalled, lowv_irq;
  int n_fail = 0, n_checks = 0, cyc = 0;
  // plain register traffic; select set before any stop, above 20 us
  srs_row_t rows [10] = '{
    '{1'b0, SRS_OFF_CAUSE, '0, '0, 32'h0000_0091, '0, SRS_RESP_OKAY},
    '{1'b1, SRS_OFF_CAUSE, 32'hffff_ffff, 4'hf, '0, '0, SRS_RESP_OKAY},
    '{1'b0, SRS_OFF_CAUSE, '0, '0, 32'h0000_0091, '0, SRS_RESP_OKAY},
    '{1'b0, SRS_OFF_CTRL, '0, '0, 32'h0000_0007, 32'h0000_0007, '0},
    '{1'b1, SRS_OFF_CTRL, 32'h0000_0003, 4'h1, '0, '0, '0},
    '{1'b1, SRS_OFF_CTRL, 32'h0000_0004, 4'h2, '0, '0, '0},
    '{1'b0, SRS_OFF_CTRL, '0, '0, 32'h0000_0007, 32'h0000_0003, '0},
    '{1'b0, 8'h10, '0, '0, 32'hffff_ffff, '0, SRS_RESP_SLVERR},
    '{1'b1, 8'h20, '0, 4'hf, '0, '0, SRS_RESP_SLVERR},
    '{1'b0, SRS_OFF_STATE, '0, '0, 32'h0000_000f, {28'h0, SRS_RUN}, '0}
  };
  srs_sequencer i_srs_sequencer (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .stop_req, .halt_req, .irq_pending,
    .cpu_on_crystal, .cpu_on_fast_int, .trap_event, .ext_reset_n_pin,
    .pwrclr_reset_n_pin, .lowv_below_pin, .ext_voltage_pin, .wdog_overflow,
    .wdog_in_standby_opt, .lowv_default_start_opt,
    .crystal_main_osc_running, .crystal_main_osc_en, .crystal_sub_osc_en,
    .int_fast_osc_en, .int_slow_osc_en, .ext_clk_in_en, .sys_reset_n,
    .wdog_reset, .lowv_reset_n, .ram_hold, .reset_low_port_pin,
    .ports_hiz, .cpu_stalled, .lowv_irq
  );
  srs_osc_model #(.STARTUP(STARTUP)) i_srs_osc_model (
    .aclk, .osc_en(crystal_main_osc_en),
    .osc_running(crystal_main_osc_running), .pin_go, .ext_reset_n_pin
  );
  // free-running clock
  initial begin
    forever #5 aclk = ~aclk;
  end
  // cycle count, also the hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // wait until a design output reaches a level; the hang guard bounds it
  task automatic till(ref logic s, input logic v);
    while (s !== v) @(posedge aclk);
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d & m, e);
  endtask
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic w;
    int t0;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    till(sys_reset_n, 1);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d, rows[i].s, r);
      end else begin
        rd(rows[i].a, d, r);
        chk(d & rows[i].m, rows[i].e);
      end
      chk({30'h0, r}, {30'h0, rows[i].resp});
    end
    $display("test register rows done");
    // stop on crystal, woken by an interrupt; select untouched meanwhile
    stop_req <= 1;
    till(cpu_stalled, 1);
    stop_req <= 0;
    t0 = cyc;
    chk(32'(int_slow_osc_en), 32'h1);
    rdc(SRS_OFF_STATE, 32'h0000_000f, {28'h0, SRS_STOP});
    irq_pending <= 1;
    till(cpu_stalled, 0);
    irq_pending <= 0;
    chk(32'(cyc - t0 >= STARTUP + WAIT3), 32'h1);
    rdc(SRS_OFF_STATUS, 32'h0000_00ff, 32'h0000_00f0);
    $display("test stop wake done");
    // pending interrupt turns stop into halt, still waits the settle time
    irq_pending <= 1;
    stop_req <= 1;
    till(cpu_stalled, 1);
    stop_req <= 0;
    t0 = cyc;
    rdc(SRS_OFF_STATE, 32'h0000_0004, 32'h0);
    till(cpu_stalled, 0);
    irq_pending <= 0;
    chk(32'(cyc - t0 >= WAIT3), 32'h1);
    $display("test halt fallback done");
    // stop refused on the fast internal clock
    cpu_on_crystal <= 0;
    cpu_on_fast_int <= 1;
    stop_req <= 1;
    repeat (20) begin
      @(posedge aclk);
      chk(32'(cpu_stalled), 32'h0);
    end
    stop_req <= 0;
    cpu_on_fast_int <= 0;
    cpu_on_crystal <= 1;
    $display("test fast clock stop done");
    // external reset ends stop
    stop_req <= 1;
    till(cpu_stalled, 1);
    stop_req <= 0;
    pin_go <= 1;
    @(posedge aclk);
    pin_go <= 0;
    till(sys_reset_n, 0);
    @(posedge aclk);
    chk({27'h0, crystal_main_osc_en, crystal_sub_osc_en, int_fast_osc_en,
         int_slow_osc_en, ext_clk_in_en}, 32'h0);
    chk({29'h0, ram_hold, reset_low_port_pin, ports_hiz}, 32'h7);
    chk(32'(lowv_reset_n), 32'h0);
    till(sys_reset_n, 1);
    $display("test external reset done");
    // watchdog overflow, then an illegal instruction
    wdog_overflow <= 1;
    @(posedge aclk);
    wdog_overflow <= 0;
    w = 0;
    repeat (10) begin
      @(posedge aclk);
      w |= wdog_reset;
    end
    chk({30'h0, w, sys_reset_n}, 32'h3);
    till(sys_reset_n, 1);
    trap_event <= 1;
    @(posedge aclk);
    trap_event <= 0;
    repeat (10) @(posedge aclk);
    till(sys_reset_n, 1);
    rdc(SRS_OFF_CAUSE, 32'h0000_0091, 32'h0000_0090);
    $display("test watchdog and trap done");
    // low-voltage reset holds while below threshold, spares the detector
    wr(SRS_OFF_CTRL, 32'h0000_0307, 4'h3, r);
    lowv_below_pin <= 1;
    repeat (20) @(posedge aclk);
    chk({30'h0, sys_reset_n, lowv_reset_n}, 32'h1);
    lowv_below_pin <= 0;
    till(sys_reset_n, 1);
    rdc(SRS_OFF_CAUSE, 32'h0000_0091, 32'h0000_0091);
    // interrupt mode from supply, then from the external pin
    for (int s = 0; s < 2; s++) begin
      wr(SRS_OFF_CTRL, s ? 32'h0000_0507 : 32'h0000_0107, 4'h3, r);
      lowv_below_pin <= (s == 0);
      ext_voltage_pin <= (s == 1);
      till(lowv_irq, 1);
      lowv_below_pin <= 0;
      ext_voltage_pin <= 0;
      rdc(SRS_OFF_CTRL, 32'h0000_0100, 32'h0);
    end
    $display("test low voltage done");
    // power-on-clear wipes every cause
    pwrclr_reset_n_pin <= 0;
    repeat (10) @(posedge aclk);
    pwrclr_reset_n_pin <= 1;
    till(sys_reset_n, 1);
    rdc(SRS_OFF_CAUSE, 32'h0000_0091, 32'h0);
    $display("test power-on-clear done");
    summarize();
  end
endmodule // srs_sequencer_bench
